// *** verilog/phyint_top.sv ***
/*
  Interrupt mask, pending status, management interrupt pin and auxiliary
  control/status registers of one PHY port.
  Assumes the management front end presents one-cycle read and write
  strobes with a 5-bit register address, and that event detectors and
  status sources run on the same clock.
*/
`timescale 1ns/10ps
// Overview of operation
// - pin follows summary when pin enabled
// - disabled pin still records pending status
// - mask enables bits 14..6, reset zero
// - mask bits 5,3..0; bit 4 reads zero
// - status bits show pending, read-only, reset zero
// - status read returns then clears set bits
// - bit 15 summarises, causes in 14..0
// - speed, duplex events need autonegotiation enabled
// - downshift event needs advertisement bits 8..5
// - no receive error during carrier extension
// - aux 15: negotiation done or link
// - aux 14: inverse of autonegotiation enable
// - aux crossover, pair swap, pair polarity flags
// - idle timeout code bits 7,2; enable 6
// - aux speed 4:3, duplex bit 5
// - aux media bits 1:0
// - sticky bits survive soft reset if enabled
module phyint_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic soft_reset_i,
  input wire logic sticky_reset_en_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [phyint_pkg::REG_W-1:0] reg_wdata_i,
  output logic [phyint_pkg::REG_W-1:0] reg_rdata_o,
  input wire logic [phyint_pkg::SRC_W-1:0] src_evt_i,
  input wire logic an_enable_i,
  input wire logic [3:0] adv_ability_i,
  input wire logic carrier_ext_decode_i,
  input wire logic an_complete_i,
  input wire logic link_up_i,
  input wire logic crossover_i,
  input wire logic pair_cd_swapped_flag_i,
  input wire logic [3:0] polarity_inv_i,
  input wire logic full_duplex_flag_i,
  input wire logic [1:0] speed_i,
  input wire logic [1:0] media_i,
  output logic mgmt_interrupt_pin_n_o,
  output logic mgmt_interrupt_pin_oe_o,
  output logic [1:0] link_idle_timeout_sel_o,
  output logic link_idle_power_save_enable_o
);
  import phyint_pkg::*;

  phyint_state_t st;
  phyint_state_t next_st;
  logic [SRC_W-1:0] evt_g;
  logic [SRC_W-1:0] pend_next;
  logic [REG_W-1:0] aux_word;
  logic rd_stat;
  logic wr_mask;
  logic wr_aux;
  logic sticky_flush;

  // register strobes, only while the clock enable is high
  assign rd_stat = ce_i && reg_rd_i && (reg_addr_i == ADDR_STAT);
  assign wr_mask = ce_i && reg_wr_i && (reg_addr_i == ADDR_MASK);
  assign wr_aux = ce_i && reg_wr_i && (reg_addr_i == ADDR_AUX);
  assign sticky_flush = soft_reset_i && !sticky_reset_en_i;

  // source qualifiers; the reserved slot can never latch
  always_comb begin
    evt_g = src_evt_i;
    evt_g[BIT_SPEED] = src_evt_i[BIT_SPEED] & an_enable_i;
    evt_g[BIT_DUPLEX] = src_evt_i[BIT_DUPLEX] & an_enable_i;
    evt_g[BIT_DOWNSHIFT] = src_evt_i[BIT_DOWNSHIFT] & (&adv_ability_i);
    evt_g[BIT_RX_ERR] = src_evt_i[BIT_RX_ERR] & ~carrier_ext_decode_i;
    evt_g[BIT_RSVD] = 1'b0;
  end

  phyint_pend_latch u_latch (
    .pend_i(st.pend[SRC_W-1:0]),
    .evt_i(evt_g),
    .clr_i(rd_stat),
    .flush_i(soft_reset_i),
    .pend_next_o(pend_next)
  );

  phyint_aux_word u_aux (
    .an_enable_i(an_enable_i),
    .an_complete_i(an_complete_i),
    .link_up_i(link_up_i),
    .crossover_i(crossover_i),
    .pair_cd_swapped_flag_i(pair_cd_swapped_flag_i),
    .polarity_inv_i(polarity_inv_i),
    .full_duplex_flag_i(full_duplex_flag_i),
    .speed_i(speed_i),
    .media_i(media_i),
    .tmo_i(st.tmo),
    .pse_i(st.pse),
    .word_o(aux_word)
  );

  // next state: writes, sticky handling, latches, summary, read data
  always_comb begin
    next_st = st;
    if (ce_i) begin
      if (wr_mask) begin
        next_st.mask = reg_wdata_i & MASK_WMASK;
      end
      if (wr_aux) begin
        next_st.tmo = {reg_wdata_i[AUX_TMO_MSB], reg_wdata_i[AUX_TMO_LSB]};
        next_st.pse = reg_wdata_i[AUX_PSE];
      end
      // soft reset with sticky retention off wins over a same-cycle write
      if (sticky_flush) begin
        next_st.mask = MASK_RST;
        next_st.tmo = AUX_TMO_RST;
        next_st.pse = AUX_PSE_RST;
      end
      // pending is recorded whatever the pin enable says
      next_st.pend[SRC_W-1:0] = pend_next;
      next_st.pend[BIT_SUMMARY] = (st.pend[BIT_SUMMARY] && !rd_stat && !soft_reset_i)
        || (|(pend_next & next_st.mask[SRC_W-1:0]));
      if (reg_rd_i) begin
        case (reg_addr_i)
          ADDR_MASK: next_st.rdata = st.mask;
          ADDR_STAT: next_st.rdata = st.pend;
          ADDR_AUX: next_st.rdata = aux_word;
          default: next_st.rdata = RDATA_RST;
        endcase
      end
      next_st.pin_drv = next_st.pend[BIT_SUMMARY] && next_st.mask[BIT_SUMMARY];
    end
  end

  // single state register, frozen while ce_i is low
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st.mask <= MASK_RST;
      st.pend <= STAT_RST;
      st.tmo <= AUX_TMO_RST;
      st.pse <= AUX_PSE_RST;
      st.rdata <= RDATA_RST;
      st.pin_drv <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // open-drain pin: only ever pulls low, released otherwise
  assign mgmt_interrupt_pin_n_o = 1'b0;
  assign mgmt_interrupt_pin_oe_o = st.pin_drv;
  assign reg_rdata_o = st.rdata;
  assign link_idle_timeout_sel_o = st.tmo;
  assign link_idle_power_save_enable_o = st.pse;

  // checks on the block's own behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_stat_read;
    ce_i && reg_rd_i && (reg_addr_i == ADDR_STAT);
  endsequence

  sequence s_aux_read;
    ce_i && reg_rd_i && (reg_addr_i == ADDR_AUX);
  endsequence

  sequence s_quiet;
    (evt_g == '0) && !soft_reset_i;
  endsequence

  property p_pin_follow;
    mgmt_interrupt_pin_oe_o == (st.pend[BIT_SUMMARY] && st.mask[BIT_SUMMARY]);
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin not following summary");

  property p_pend_no_pin;
    ce_i && src_evt_i[BIT_LINK] && !st.mask[BIT_SUMMARY] && !reg_wr_i
      |=> st.pend[BIT_LINK] && !mgmt_interrupt_pin_oe_o;
  endproperty
  a_pend_no_pin: assert property (p_pend_no_pin) else $error("pending lost with pin off");

  property p_mask_write;
    ce_i && reg_wr_i && (reg_addr_i == ADDR_MASK) && !soft_reset_i
      |=> st.mask == ($past(reg_wdata_i) & MASK_WMASK);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

  property p_rsvd_zero;
    !st.mask[BIT_RSVD] && !st.pend[BIT_RSVD];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit 4 set");

  property p_stat_read_clear;
    s_stat_read ##0 s_quiet |=> (reg_rdata_o == $past(st.pend)) && (st.pend == STAT_RST);
  endproperty
  a_stat_read_clear: assert property (p_stat_read_clear) else $error("status read not cleared");

  property p_speed_gate;
    ce_i && !an_enable_i && !st.pend[BIT_SPEED] && !st.pend[BIT_DUPLEX]
      |=> !st.pend[BIT_SPEED] && !st.pend[BIT_DUPLEX];
  endproperty
  a_speed_gate: assert property (p_speed_gate) else $error("speed/duplex without aneg");

  property p_downshift_gate;
    ce_i && !(&adv_ability_i) && !st.pend[BIT_DOWNSHIFT] |=> !st.pend[BIT_DOWNSHIFT];
  endproperty
  a_downshift_gate: assert property (p_downshift_gate) else $error("downshift not gated");

  property p_rxerr_gate;
    ce_i && carrier_ext_decode_i && !st.pend[BIT_RX_ERR] |=> !st.pend[BIT_RX_ERR];
  endproperty
  a_rxerr_gate: assert property (p_rxerr_gate) else $error("rx error during extension");

  property p_aux_read;
    s_aux_read |=> (reg_rdata_o[AUX_ANEG_OFF] == !$past(an_enable_i))
      && (reg_rdata_o[AUX_ANEG_DONE] ==
        ($past(an_enable_i) ? $past(an_complete_i) : $past(link_up_i)))
      && (reg_rdata_o[AUX_SPEED_LSB +: 2] == $past(speed_i))
      && (reg_rdata_o[AUX_TMO_MSB] == $past(st.tmo[1]));
  endproperty
  a_aux_read: assert property (p_aux_read) else $error("aux read word wrong");

  property p_sticky_keep;
    ce_i && soft_reset_i && sticky_reset_en_i && !reg_wr_i
      |=> $stable(st.mask) && $stable(st.tmo) && $stable(st.pse);
  endproperty
  a_sticky_keep: assert property (p_sticky_keep) else $error("sticky lost on soft reset");

  property p_sticky_clear;
    ce_i && soft_reset_i && !sticky_reset_en_i
      |=> (st.mask == MASK_RST) && (st.tmo == AUX_TMO_RST) && !st.pse;
  endproperty
  a_sticky_clear: assert property (p_sticky_clear) else $error("sticky not defaulted");

  // a status read in the same cycle clears the summary, so it is left out of both steps
  property p_summary_set;
    ce_i && !reg_wr_i && !rd_stat && !soft_reset_i
      && (|(st.pend[SRC_W-1:0] & st.mask[SRC_W-1:0]))
      |=> st.pend[BIT_SUMMARY]
        and ((ce_i && !rd_stat && !soft_reset_i) |=> st.pend[BIT_SUMMARY]);
  endproperty
  a_summary_set: assert property (p_summary_set) else $error("summary not set");

endmodule : phyint_top

// *** verilog/phyint_pkg.sv ***
/*
  Constants and state type for the management interrupt and auxiliary
  status block of one copper PHY port.
  Assumes a 5-bit internal register address from the management front end.
*/
package phyint_pkg;

  // register addresses inside the main register space
  localparam logic [4:0] ADDR_MASK = 5'h19;
  localparam logic [4:0] ADDR_STAT = 5'h1a;
  localparam logic [4:0] ADDR_AUX = 5'h1c;

  // widths
  localparam int SRC_W = 15;
  localparam int REG_W = 16;

  // mask and status share one bit layout
  localparam int BIT_SUMMARY = 15;
  localparam int BIT_SPEED = 14;
  localparam int BIT_LINK = 13;
  localparam int BIT_DUPLEX = 12;
  localparam int BIT_ANEG_ERR = 11;
  localparam int BIT_ANEG_DONE = 10;
  localparam int BIT_PD_DET = 9;
  localparam int BIT_SYM_ERR = 8;
  localparam int BIT_FAST_FAIL = 7;
  localparam int BIT_EXT = 5;
  localparam int BIT_RSVD = 4;
  localparam int BIT_FALSE_CARR = 3;
  localparam int BIT_DOWNSHIFT = 2;
  localparam int BIT_MS_ERR = 1;
  localparam int BIT_RX_ERR = 0;

  // auxiliary_control_status layout
  localparam int AUX_ANEG_DONE = 15;
  localparam int AUX_ANEG_OFF = 14;
  localparam int AUX_XOVER = 13;
  localparam int AUX_CD_SWAP = 12;
  localparam int AUX_POL_LSB = 8;
  localparam int AUX_TMO_MSB = 7;
  localparam int AUX_PSE = 6;
  localparam int AUX_FDX = 5;
  localparam int AUX_SPEED_LSB = 3;
  localparam int AUX_TMO_LSB = 2;
  localparam int AUX_MEDIA_LSB = 0;

  // values after reset and writable bits
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] MASK_WMASK = 16'hffef;
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic [1:0] AUX_TMO_RST = 2'h1;
  localparam logic AUX_PSE_RST = 1'b0;

  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] pend;
    logic [1:0] tmo;
    logic pse;
    logic [15:0] rdata;
    logic pin_drv;
  } phyint_state_t;

endpackage : phyint_pkg

// *** verilog/phyint_pend_latch.sv ***
/*
  Next-state logic of the per-source pending latches.
  Assumes events are one-cycle pulses already gated by their conditions.
*/
`timescale 1ns/10ps
module phyint_pend_latch (
  input wire logic [phyint_pkg::SRC_W-1:0] pend_i,
  input wire logic [phyint_pkg::SRC_W-1:0] evt_i,
  input wire logic clr_i,
  input wire logic flush_i,
  output logic [phyint_pkg::SRC_W-1:0] pend_next_o
);
  import phyint_pkg::*;

  // an event in the clearing cycle wins, so nothing is lost
  for (genvar i = 0; i < SRC_W; i++) begin : g_bit
    assign pend_next_o[i] = evt_i[i] | (pend_i[i] & ~clr_i & ~flush_i);
  end

endmodule : phyint_pend_latch

// *** verilog/phyint_aux_word.sv ***
/*
  Builds the auxiliary_control_status read word.
  Assumes all status inputs come from logic on the same clock.
*/
`timescale 1ns/10ps
module phyint_aux_word (
  input wire logic an_enable_i,
  input wire logic an_complete_i,
  input wire logic link_up_i,
  input wire logic crossover_i,
  input wire logic pair_cd_swapped_flag_i,
  input wire logic [3:0] polarity_inv_i,
  input wire logic full_duplex_flag_i,
  input wire logic [1:0] speed_i,
  input wire logic [1:0] media_i,
  input wire logic [1:0] tmo_i,
  input wire logic pse_i,
  output logic [phyint_pkg::REG_W-1:0] word_o
);
  import phyint_pkg::*;

  // live flags next to the stored power-save controls
  always_comb begin
    word_o = '0;
    word_o[AUX_ANEG_DONE] = an_enable_i ? an_complete_i : link_up_i;
    word_o[AUX_ANEG_OFF] = ~an_enable_i;
    word_o[AUX_XOVER] = crossover_i;
    word_o[AUX_CD_SWAP] = pair_cd_swapped_flag_i;
    word_o[AUX_POL_LSB +: 4] = polarity_inv_i;
    word_o[AUX_TMO_MSB] = tmo_i[1];
    word_o[AUX_TMO_LSB] = tmo_i[0];
    word_o[AUX_PSE] = pse_i;
    word_o[AUX_FDX] = full_duplex_flag_i;
    word_o[AUX_SPEED_LSB +: 2] = speed_i;
    word_o[AUX_MEDIA_LSB +: 2] = media_i;
  end

endmodule : phyint_aux_word

// *** dv/phyint_mgmt_model.sv ***
/*
  Station management controller model that polls the port registers.
  Assumes one-cycle strobes launched at the falling edge of clk_i.
*/
`timescale 1ns/10ps
module phyint_mgmt_model (
  input wire logic clk_i,
  output logic [4:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i
);
  // bus idle at time zero
  initial begin
    reg_addr_o = 5'h00;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  // write held over one sampling edge, data then scrambled so a stale value never matches
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask : wr

  // read data is registered, so it is taken at the falling edge half a cycle after the read edge
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask : rd
endmodule : phyint_mgmt_model

// *** dv/phy_interrupt_and_aux_status_tb.sv ***
/*
  Self-checking bench for the port interrupt and auxiliary status block.
  Assumes the management model in dv/ and inputs driven at falling edges.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module phy_interrupt_and_aux_status_tb;
  import phyint_pkg::*;
  typedef struct packed {logic [13:0] in; logic [15:0] exp;} phyint_row_t;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic soft_i = 1'b0;
  logic sticky_i = 1'b0;
  logic cext = 1'b0;
  logic [3:0] adv = 4'hf;
  logic [14:0] evt = 15'h0000;
  logic [13:0] st = 14'h3559;
  logic [4:0] addr;
  logic rd;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic pin_oe;
  logic pin_n;
  logic [1:0] sel;
  logic pse;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  // aux inputs {an_en, an_done, link, xover, swap, pol, fdx, speed, media} with reset controls
  phyint_row_t rows [3] = '{'{14'h3559, 16'haa35}, '{14'h0aa4, 16'hd50c},
    '{14'h2800, 16'h0004}};

  always #50 clk_i = ~clk_i;

  phyint_mgmt_model i_mm (.clk_i(clk_i), .reg_addr_o(addr), .reg_rd_o(rd),
    .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  phyint_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .soft_reset_i(soft_i), .sticky_reset_en_i(sticky_i), .reg_addr_i(addr),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .src_evt_i(evt), .an_enable_i(st[13]), .adv_ability_i(adv),
    .carrier_ext_decode_i(cext), .an_complete_i(st[12]), .link_up_i(st[11]),
    .crossover_i(st[10]), .pair_cd_swapped_flag_i(st[9]),
    .polarity_inv_i(st[8:5]), .full_duplex_flag_i(st[4]), .speed_i(st[3:2]),
    .media_i(st[1:0]), .mgmt_interrupt_pin_n_o(pin_n), .mgmt_interrupt_pin_oe_o(pin_oe),
    .link_idle_timeout_sel_o(sel), .link_idle_power_save_enable_o(pse));

  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // hang guard, the whole run needs well under 400 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      conclude();
    end
  end

  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    i_mm.rd(a, d);
    `CHK(d, e)
  endtask : rdc

  // one-cycle event and soft reset pulses
  task automatic pulse(input logic [14:0] e, input logic s);
    @(negedge clk_i);
    evt = e;
    soft_i = s;
    @(negedge clk_i);
    evt = 15'h0000;
    soft_i = 1'b0;
  endtask : pulse

  initial begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) reset_i = 1'b0;
    `CHK({pin_oe, pse, sel}, 4'h1)
    rdc(ADDR_MASK, 16'h0000);
    rdc(ADDR_STAT, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      st = rows[i].in;
      rdc(ADDR_AUX, rows[i].exp);
    end
    rdc(5'h1b, 16'h0000);
    i_mm.wr(ADDR_MASK, 16'hffff);
    rdc(ADDR_MASK, 16'hffef);
    i_mm.wr(ADDR_STAT, 16'hffff);
    rdc(ADDR_STAT, 16'h0000);
    // pin disabled: pending still recorded
    i_mm.wr(ADDR_MASK, 16'h2000);
    pulse(15'h2000, 1'b0);
    `CHK(pin_oe, 1'b0)
    rdc(ADDR_STAT, 16'ha000);
    rdc(ADDR_STAT, 16'h0000);
    pulse(15'h0100, 1'b0);
    rdc(ADDR_STAT, 16'h0100);
    rdc(ADDR_STAT, 16'h0000);
    i_mm.wr(ADDR_MASK, 16'ha000);
    `CHK(pin_oe, 1'b0)
    pulse(15'h2000, 1'b0);
    `CHK(pin_oe, 1'b1)
    `CHK(pin_n, 1'b0)
    rdc(ADDR_STAT, 16'ha000);
    `CHK(pin_oe, 1'b0)
    // gated sources, blocked then allowed
    st[13] = 1'b0;
    cext = 1'b1;
    adv = 4'h7;
    pulse(15'h5005, 1'b0);
    rdc(ADDR_STAT, 16'h0000);
    st[13] = 1'b1;
    cext = 1'b0;
    adv = 4'hf;
    pulse(15'h5005, 1'b0);
    rdc(ADDR_STAT, 16'h5005);
    // extended source: the cause itself sits on an extended page beyond this block
    pulse(15'h0020, 1'b0);
    rdc(ADDR_STAT, 16'h0020);
    // every timeout code with the mode enabled
    for (int k = 0; k < 4; k++) begin
      i_mm.wr(ADDR_AUX, {8'h0f, k[1], 1'b1, 3'h0, k[0], 2'h0});
      `CHK({pse, sel}, {1'b1, k[1:0]})
    end
    rdc(ADDR_AUX, 16'h00c4);
    // soft reset keeps sticky bits only while enabled
    sticky_i = 1'b1;
    pulse(15'h2000, 1'b0);
    pulse(15'h0000, 1'b1);
    `CHK({pin_oe, pse, sel}, 4'h7)
    rdc(ADDR_MASK, 16'ha000);
    rdc(ADDR_STAT, 16'h0000);
    sticky_i = 1'b0;
    pulse(15'h0000, 1'b1);
    `CHK({pse, sel}, 3'h1)
    rdc(ADDR_MASK, 16'h0000);
    // clock enable low: events and writes are both lost
    ce_i = 1'b0;
    pulse(15'h2000, 1'b0);
    i_mm.wr(ADDR_MASK, 16'h2000);
    ce_i = 1'b1;
    rdc(ADDR_STAT, 16'h0000);
    rdc(ADDR_MASK, 16'h0000);
    // hardware reset in mid-run drops pending and the idle timeout code
    i_mm.wr(ADDR_AUX, 16'h0084);
    pulse(15'h2000, 1'b0);
    @(negedge clk_i) reset_i = 1'b1;
    @(negedge clk_i) reset_i = 1'b0;
    `CHK({pin_oe, pse, sel}, 4'h1)
    rdc(ADDR_STAT, 16'h0000);
    rdc(ADDR_AUX, 16'h0004);
    conclude();
  end
endmodule : phy_interrupt_and_aux_status_tb
